// File: freq_stage_status.v
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "fsl_map.vh"
// Operation
// RULE1: trip follows start after one fixed delay; no other curve exists.
// RULE2: each stage reports normal, start, trip or blocked as a 2-bit code.
// RULE3: ratio of measured frequency to pick-up is readable in 0.001 steps.
// RULE4: expected operating time readable in 5 ms steps, clamped to max delay.
// RULE5: signed time left to trip readable while timing.
// RULE6: blocking inputs sampled once at each program cycle start.
// RULE7: each stage has its own blocking input bit.
// RULE8: pick-up without blocking gives start and runs trip timing.
// RULE9: pick-up with blocking gives blocked, no start, no timing.
// RULE10: blocking after start drops start as if pick-up released.
// RULE11: blocking source must assert 5 ms before the delay ends.
// RULE12: ON and OFF events for start, trip and blocked changes.
// RULE13: per event kind mask chooses ON, OFF or both for the buffer.
// RULE14: each event carries a time stamp taken when it occurs.
// RULE15: resettable counters for start, trip and blocked per stage.
// RULE16: last twelve operation records kept in a circular store.
// RULE17: record holds time, event, pre-trigger and fault frequency, group.
// RULE18: start, trip, blocked are direct outputs for relays and logic.
// RULE19: 20 mHz release hysteresis relative to pick-up.
// RULE20: four over- and four underfrequency stages, each enabled alone.
// RULE21: with forcing enabled a stage shows its forced condition.
// RULE22: delay counter advances per 5 ms cycle, trips on reaching delay.
module freq_stage_status #(
   parameter FW = 17,
   parameter DW = 19,
   parameter CYCLE_CLKS = `CYCLE_TIME_NS / `CLK_PERIOD_NS
)(
   // clock and reset
   input wire CLOCK,
   input wire RST,
   // register port
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   // measurement and context
   input wire [FW-1:0] FREQ,
   input wire [2:0] SET_GROUP,
   input wire [31:0] TIME_STAMP,
   // blocking matrix, one bit per stage, over stages first
   input wire [7:0] BLOCK,
   // stage outputs
   output reg [7:0] START,
   output reg [7:0] TRIP,
   output reg [7:0] BLOCKED,
   // event stream to the main buffer
   output reg EVT_VALID,
   output reg [5:0] EVT_CODE,
   output reg [31:0] EVT_TIME
);
   localparam NST = 8;
   localparam PRE = `PRE_TRIG_MS / `CYCLE_MS;

   // lowest set bit of a pending vector
   function [6:0] first_one;
      input [63:0] v;
      integer n;
      begin
         first_one = 7'h00;
         for (n = 63; n >= 0; n = n - 1)
            if (v[n])
               first_one = {1'b1, n[5:0]};
      end
   endfunction

   // per unit ratio, zero when the pick-up is zero
   function [31:0] ratio;
      input [FW-1:0] f;
      input [FW-1:0] p;
      reg [31:0] num;
      begin
         num = {{(32-FW){1'b0}}, f} * `RATIO_SCALE;
         ratio = (p == {FW{1'b0}}) ? 32'h0 : num / {{(32-FW){1'b0}}, p};
      end
   endfunction

   reg [31:0] cyc_q;
   reg tick_q;
   reg eval_q;
   reg [7:0] blk_q;
   reg [FW-1:0] freq_q;
   reg [FW-1:0] hist_q [0:PRE-1];
   reg force_en_q;
   reg [2:0] sel_q;
   reg [5:0] mask_q;
   reg [7:0] enable_q;
   reg [FW-1:0] pickup_q [0:NST-1];
   reg [DW-1:0] delay_q [0:NST-1];
   reg [1:0] frc_q [0:NST-1];
   reg [1:0] status_q [0:NST-1];
   reg [15:0] cnt_q [0:3*NST-1];
   reg [63:0] pend_q;
   reg [31:0] evstamp_q;
   reg [3:0] rsel_q;
   wire [2*NST-1:0] st_all;
   wire [(DW+1)*NST-1:0] rem_all;
   reg [7:0] n_start;
   reg [7:0] n_trip;
   reg [7:0] n_blk;
   reg [1:0] sh;
   reg [63:0] pset;
   integer k, j;
   wire [6:0] fo = first_one(pend_q);
   wire [63:0] pclr = fo[6] ? (64'h1 << fo[5:0]) : 64'h0;
   wire rec_wr = fo[6] && !fo[0] && (fo[2:1] != `EV_BLOCKED);
   wire [31:0] rec_stamp;
   wire [5:0] rec_event;
   wire [FW-1:0] rec_pre;
   wire [FW-1:0] rec_fault;
   wire [2:0] rec_group;
   wire [3:0] rec_count;
   wire [DW:0] rem_sel = rem_all[sel_q*(DW+1) +: DW+1];
   wire [4:0] cbase = {2'b00, sel_q} + {1'b0, sel_q, 1'b0};
   wire clr_s = WR && (ADDR == `A_CNT_START);
   wire clr_t = WR && (ADDR == `A_CNT_TRIP);
   wire clr_b = WR && (ADDR == `A_CNT_BLK);

   // program cycle pacing: sample at tick, evaluate the cycle after
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         cyc_q <= 32'h0;
         tick_q <= 1'b0;
         eval_q <= 1'b0;
         blk_q <= 8'h00;
         freq_q <= {FW{1'b0}};
      end
      else
      begin
         tick_q <= (cyc_q == CYCLE_CLKS - 1);
         cyc_q <= (cyc_q == CYCLE_CLKS - 1) ? 32'h0 : cyc_q + 32'h1;
         eval_q <= tick_q;
         if (tick_q)
         begin
            blk_q <= BLOCK; // RULE6 RULE7
            freq_q <= FREQ;
         end
      end
   end

   // frequency history for the pre-trigger value
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         for (k = 0; k < PRE; k = k + 1)
            hist_q[k] <= {FW{1'b0}};
      end
      else if (tick_q)
      begin
         hist_q[0] <= freq_q;
         for (k = 1; k < PRE; k = k + 1)
            hist_q[k] <= hist_q[k-1];
      end
   end

   // four over stages then four under stages
   genvar i;
   generate
      for (i = 0; i < NST; i = i + 1)
      begin : stg
         freq_stage #(
            .OVER(i < NST / 2 ? 1 : 0), // RULE20
            .FW(FW),
            .DW(DW)
         ) u_stage (
            .clk(CLOCK),
            .rst(RST),
            .tick(eval_q),
            .enable(enable_q[i]), // RULE20
            .block(blk_q[i]), // RULE7
            .freq(freq_q),
            .pickup(pickup_q[i]),
            .delay(delay_q[i]),
            .state_q(st_all[2*i +: 2]),
            .remain(rem_all[(DW+1)*i +: DW+1])
         );
      end
   endgenerate

   // shown condition with forcing, and event edges
   always @*
   begin
      pset = 64'h0;
      sh = `ST_NORMAL;
      for (j = 0; j < NST; j = j + 1)
      begin
         sh = force_en_q ? frc_q[j] : st_all[2*j +: 2]; // RULE21
         n_start[j] = (sh == `ST_START) || (sh == `ST_TRIP);
         n_trip[j] = (sh == `ST_TRIP);
         n_blk[j] = (sh == `ST_BLOCKED);
         pset[8*j] = n_start[j] & ~START[j]; // RULE12
         pset[8*j+1] = ~n_start[j] & START[j];
         pset[8*j+2] = n_trip[j] & ~TRIP[j];
         pset[8*j+3] = ~n_trip[j] & TRIP[j];
         pset[8*j+4] = n_blk[j] & ~BLOCKED[j];
         pset[8*j+5] = ~n_blk[j] & BLOCKED[j];
      end
   end

   // outputs, pending events and stamps
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         START <= 8'h00;
         TRIP <= 8'h00;
         BLOCKED <= 8'h00;
         pend_q <= 64'h0;
         evstamp_q <= 32'h0;
         EVT_VALID <= 1'b0;
         EVT_CODE <= 6'h00;
         EVT_TIME <= 32'h0;
         for (k = 0; k < NST; k = k + 1)
            status_q[k] <= `ST_NORMAL;
      end
      else
      begin
         START <= n_start; // RULE18
         TRIP <= n_trip; // RULE18
         BLOCKED <= n_blk; // RULE18
         for (k = 0; k < NST; k = k + 1)
            status_q[k] <= {n_trip[k] | n_blk[k], n_blk[k] | (n_start[k] & ~n_trip[k])}; // RULE2
         pend_q <= (pend_q & ~pclr) | pset; // new edge wins over clear
         if (|pset)
            evstamp_q <= TIME_STAMP; // RULE14
         EVT_VALID <= fo[6] && mask_q[{fo[2:1], fo[0]}]; // RULE13
         EVT_CODE <= fo[5:0];
         EVT_TIME <= evstamp_q; // RULE14
      end
   end

   // settings written over the register port
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         force_en_q <= 1'b0;
         sel_q <= 3'h0;
         mask_q <= `MASK_RST;
         enable_q <= 8'h00;
         rsel_q <= 4'h0;
         for (k = 0; k < NST; k = k + 1)
         begin
            pickup_q[k] <= (k < NST / 2) ? `PICKUP_OVER_RST : `PICKUP_UNDER_RST;
            delay_q[k] <= `DELAY_RST;
            frc_q[k] <= `ST_NORMAL;
         end
      end
      else if (WR)
      begin
         case (ADDR)
            `A_CTRL: force_en_q <= WDATA[0];
            `A_SEL: sel_q <= WDATA[2:0];
            `A_MASK: mask_q <= WDATA[5:0];
            `A_ENABLE: enable_q <= WDATA[7:0];
            `A_PICKUP: pickup_q[sel_q] <= WDATA[FW-1:0];
            `A_DELAY: delay_q[sel_q] <= (WDATA > `MAX_DELAY) ? `MAX_DELAY : WDATA[DW-1:0]; // RULE4
            `A_FORCE: frc_q[sel_q] <= WDATA[1:0];
            `A_REC_SEL: rsel_q <= (WDATA[3:0] > 4'hB) ? 4'hB : WDATA[3:0];
            default: force_en_q <= force_en_q;
         endcase
      end
   end

   // cumulative counters, an increment and a clear in the same cycle leave a count of 1
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
      begin
         for (k = 0; k < 3 * NST; k = k + 1)
            cnt_q[k] <= 16'h0000;
      end
      else
      begin
         for (k = 0; k < NST; k = k + 1)
         begin
            if (pset[8*k])
               cnt_q[3*k] <= (clr_s && sel_q == k) ? 16'h0001 : cnt_q[3*k] + 16'h0001; // RULE15
            else if (clr_s && sel_q == k)
               cnt_q[3*k] <= 16'h0000;
            if (pset[8*k+2])
               cnt_q[3*k+1] <= (clr_t && sel_q == k) ? 16'h0001 : cnt_q[3*k+1] + 16'h0001;
            else if (clr_t && sel_q == k)
               cnt_q[3*k+1] <= 16'h0000; // RULE15
            if (pset[8*k+4])
               cnt_q[3*k+2] <= (clr_b && sel_q == k) ? 16'h0001 : cnt_q[3*k+2] + 16'h0001;
            else if (clr_b && sel_q == k)
               cnt_q[3*k+2] <= 16'h0000;
         end
      end
   end

   // operation records on start ON and trip ON
   op_record_store #(
      .DEPTH(12),
      .FW(FW)
   ) u_rec (
      .clk(CLOCK),
      .rst(RST),
      .wr(rec_wr), // RULE16
      .stamp(evstamp_q), // RULE17
      .event_code(fo[5:0]),
      .pre_freq(hist_q[PRE-1]), // RULE17
      .fault_freq(freq_q),
      .group(SET_GROUP),
      .sel(rsel_q),
      .rd_stamp(rec_stamp),
      .rd_event(rec_event),
      .rd_pre(rec_pre),
      .rd_fault(rec_fault),
      .rd_group(rec_group),
      .count_q(rec_count)
   );

   // read data, valid the cycle after the strobe only
   always @(posedge CLOCK or posedge RST)
   begin
      if (RST)
         RDATA <= 32'h0;
      else if (!RD)
         RDATA <= 32'h0;
      else
      begin
         case (ADDR)
            `A_CTRL: RDATA <= {31'h0, force_en_q};
            `A_SEL: RDATA <= {29'h0, sel_q};
            `A_MASK: RDATA <= {26'h0, mask_q};
            `A_ENABLE: RDATA <= {24'h0, enable_q};
            `A_PICKUP: RDATA <= {{(32-FW){1'b0}}, pickup_q[sel_q]};
            `A_DELAY: RDATA <= {{(32-DW){1'b0}}, delay_q[sel_q]};
            `A_FORCE: RDATA <= {30'h0, frc_q[sel_q]};
            `A_STATUS: RDATA <= {30'h0, status_q[sel_q]}; // RULE2
            `A_RATIO: RDATA <= ratio(freq_q, pickup_q[sel_q]); // RULE3
            `A_EXPECT: RDATA <= {{(32-DW){1'b0}}, delay_q[sel_q]}; // RULE4
            `A_REMAIN: RDATA <= {{(31-DW){rem_sel[DW]}}, rem_sel}; // RULE5
            `A_CNT_START: RDATA <= {16'h0, cnt_q[cbase]};
            `A_CNT_TRIP: RDATA <= {16'h0, cnt_q[cbase+5'h01]};
            `A_CNT_BLK: RDATA <= {16'h0, cnt_q[cbase+5'h02]};
            `A_REC_SEL: RDATA <= {28'h0, rsel_q};
            `A_REC_TIME: RDATA <= rec_stamp;
            `A_REC_EVENT: RDATA <= {26'h0, rec_event};
            `A_REC_PRE: RDATA <= {{(32-FW){1'b0}}, rec_pre};
            `A_REC_FAULT: RDATA <= {{(32-FW){1'b0}}, rec_fault};
            `A_REC_GROUP: RDATA <= {29'h0, rec_group};
            `A_REC_COUNT: RDATA <= {28'h0, rec_count};
            default: RDATA <= 32'h0;
         endcase
      end
   end
endmodule

// File: fsl_map.vh
`ifndef FSL_MAP_VH
`define FSL_MAP_VH
// timing
`define CLK_PERIOD_NS 4
`define CYCLE_TIME_NS 5000000
`define PRE_TRIG_MS 20
`define CYCLE_MS 5
// measurement and delay limits, frequencies in mHz
`define HYST_MHZ 18'h00014
`define MAX_DELAY 19'h57E40
`define RATIO_SCALE 1000
`define PICKUP_OVER_RST 17'h0C738
`define PICKUP_UNDER_RST 17'h0BF68
`define DELAY_RST 19'h00014
`define MASK_RST 6'h3F
// stage condition codes
`define ST_NORMAL 2'h0
`define ST_START 2'h1
`define ST_TRIP 2'h2
`define ST_BLOCKED 2'h3
// event kinds
`define EV_START 2'h0
`define EV_TRIP 2'h1
`define EV_BLOCKED 2'h2
// register offsets
`define A_CTRL 8'h00
`define A_SEL 8'h01
`define A_MASK 8'h02
`define A_ENABLE 8'h03
`define A_PICKUP 8'h04
`define A_DELAY 8'h05
`define A_FORCE 8'h06
`define A_STATUS 8'h07
`define A_RATIO 8'h08
`define A_EXPECT 8'h09
`define A_REMAIN 8'h0A
`define A_CNT_START 8'h0B
`define A_CNT_TRIP 8'h0C
`define A_CNT_BLK 8'h0D
`define A_REC_SEL 8'h0E
`define A_REC_TIME 8'h0F
`define A_REC_EVENT 8'h10
`define A_REC_PRE 8'h11
`define A_REC_FAULT 8'h12
`define A_REC_GROUP 8'h13
`define A_REC_COUNT 8'h14
`endif

// File: freq_stage.v
`timescale 1ns/100ps
`include "fsl_map.vh"
module freq_stage #(
   parameter OVER = 1,
   parameter FW = 17,
   parameter DW = 19
)(
   // clock and reset
   input wire clk,
   input wire rst,
   // evaluation
   input wire tick,
   input wire enable,
   input wire block,
   input wire [FW-1:0] freq,
   input wire [FW-1:0] pickup,
   input wire [DW-1:0] delay,
   // result
   output reg [1:0] state_q,
   output wire [DW:0] remain
);
   reg picked_q;
   reg [DW-1:0] timer_q;
   wire [FW:0] f_ext = {1'b0, freq};
   wire [FW:0] p_ext = {1'b0, pickup};
   wire [FW:0] hyst = `HYST_MHZ;
   wire hit = OVER ? (f_ext > p_ext) : (f_ext < p_ext);
   // release only once past the pick-up by the hysteresis
   wire rel = OVER ? (f_ext + hyst < p_ext) : (f_ext > p_ext + hyst); // RULE19
   wire pick_d = picked_q ? !rel : hit;
   wire [DW-1:0] tnext = timer_q + {{(DW-1){1'b0}}, 1'b1};
   // signed time left until trip
   assign remain = {1'b0, delay} - {1'b0, timer_q}; // RULE5
   // one evaluation per program cycle, fixed delay only
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         picked_q <= 1'b0;
         timer_q <= {DW{1'b0}};
         state_q <= `ST_NORMAL;
      end
      else if (tick)
      begin
         if (!enable)
         begin
            picked_q <= 1'b0;
            timer_q <= {DW{1'b0}};
            state_q <= `ST_NORMAL;
         end
         else
         begin
            picked_q <= pick_d;
            if (pick_d && block)
            begin
               timer_q <= {DW{1'b0}}; // RULE9 RULE10
               state_q <= `ST_BLOCKED; // RULE9
            end
            else if (pick_d)
            begin
               if (tnext >= delay) // RULE1 RULE22
               begin
                  timer_q <= delay;
                  state_q <= `ST_TRIP;
               end
               else
               begin
                  timer_q <= tnext; // RULE8 RULE22
                  state_q <= `ST_START; // RULE8
               end
            end
            else
            begin
               timer_q <= {DW{1'b0}};
               state_q <= `ST_NORMAL;
            end
         end
      end
   end
endmodule

// File: op_record_store.v
`timescale 1ns/100ps
`include "fsl_map.vh"
module op_record_store #(
   parameter DEPTH = 12,
   parameter FW = 17
)(
   // clock and reset
   input wire clk,
   input wire rst,
   // write side
   input wire wr,
   input wire [31:0] stamp,
   input wire [5:0] event_code,
   input wire [FW-1:0] pre_freq,
   input wire [FW-1:0] fault_freq,
   input wire [2:0] group,
   // read side, 0 is newest
   input wire [3:0] sel,
   output wire [31:0] rd_stamp,
   output wire [5:0] rd_event,
   output wire [FW-1:0] rd_pre,
   output wire [FW-1:0] rd_fault,
   output wire [2:0] rd_group,
   output reg [3:0] count_q
);
   reg [31:0] stamp_m [0:DEPTH-1];
   reg [5:0] event_m [0:DEPTH-1];
   reg [FW-1:0] pre_m [0:DEPTH-1];
   reg [FW-1:0] fault_m [0:DEPTH-1];
   reg [2:0] group_m [0:DEPTH-1];
   reg [3:0] wp_q;
   wire [31:0] last_w = DEPTH - 1;
   wire [3:0] last = last_w[3:0];
   wire [3:0] ph = (wp_q > sel) ? wp_q - 4'h1 - sel : wp_q + last - sel;
   assign rd_stamp = stamp_m[ph];
   assign rd_event = event_m[ph];
   assign rd_pre = pre_m[ph];
   assign rd_fault = fault_m[ph];
   assign rd_group = group_m[ph];
   // circular write, oldest entry overwritten
   always @(posedge clk)
   begin
      if (wr)
      begin
         stamp_m[wp_q] <= stamp; // RULE16 RULE17
         event_m[wp_q] <= event_code;
         pre_m[wp_q] <= pre_freq;
         fault_m[wp_q] <= fault_freq;
         group_m[wp_q] <= group;
      end
   end
   // pointer and fill level
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_q <= 4'h0;
         count_q <= 4'h0;
      end
      else if (wr)
      begin
         wp_q <= (wp_q == last) ? 4'h0 : wp_q + 4'h1; // RULE16
         if (count_q != DEPTH)
            count_q <= count_q + 4'h1;
      end
   end
endmodule

// File: stage_status_monitor.sv
`timescale 1ns/100ps
`include "fsl_map.vh"
module stage_status_monitor (
   // clock and reset
   input wire CLOCK,
   input wire RST,
   // register port
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   input wire [31:0] RDATA,
   // stage outputs and events
   input wire [7:0] START,
   input wire [7:0] TRIP,
   input wire [7:0] BLOCKED,
   input wire EVT_VALID,
   input wire [5:0] EVT_CODE
);
   reg [5:0] mask_q;
   reg [5:0] mask_p_q;
   // shadow of the event mask, plus its value one cycle back for registered events
   always @(posedge CLOCK or posedge RST)
      if (RST)
      begin
         mask_q <= `MASK_RST;
         mask_p_q <= `MASK_RST;
      end
      else
      begin
         mask_p_q <= mask_q;
         if (WR && ADDR == `A_MASK)
            mask_q <= WDATA[5:0];
      end
   default clocking @(posedge CLOCK); endclocking
   default disable iff (RST);
   // a read strobe at one address, and at any address past the end of the map
   sequence s_rd_at(a);
      RD && ADDR == a;
   endsequence
   sequence s_rd_hole;
      RD && ADDR > `A_REC_COUNT;
   endsequence
   property p_trip_start;
      (TRIP & ~START) == 8'h00;
   endproperty
   property p_blk_excl;
      (BLOCKED & START) == 8'h00;
   endproperty
   property p_rd_idle;
      !$past(RD) |-> RDATA == 32'h0;
   endproperty
   property p_unmapped;
      s_rd_hole |=> RDATA == 32'h0;
   endproperty
   property p_reset_quiet;
      $fell(RST) |-> (START | TRIP | BLOCKED) == 8'h00 && !EVT_VALID;
   endproperty
   property p_evt_mask;
      EVT_VALID |-> mask_p_q[{EVT_CODE[2:1], EVT_CODE[0]}];
   endproperty
   property p_evt_kind;
      EVT_VALID |-> EVT_CODE[2:1] != 2'h3;
   endproperty
   property p_rec_count;
      s_rd_at(`A_REC_COUNT) |=> RDATA <= 32'h0000000C;
   endproperty
   property p_status_code;
      s_rd_at(`A_STATUS) |=> RDATA[31:2] == 30'h0;
   endproperty
   property p_mask_read;
      s_rd_at(`A_MASK) |=> RDATA == {26'h0, $past(mask_q)};
   endproperty
   property p_event_follow;
      $rose(START[0]) && mask_q[0] |-> ##[1:60] EVT_VALID;
   endproperty
   a_trip_start: assert property (p_trip_start) else $error("trip without start");
   a_blk_excl: assert property (p_blk_excl) else $error("start while blocked");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs after reset");
   a_evt_mask: assert property (p_evt_mask) else $error("masked event sent");
   a_evt_kind: assert property (p_evt_kind) else $error("bad event kind");
   a_rec_count: assert property (p_rec_count) else $error("record count over 12");
   a_status_code: assert property (p_status_code) else $error("status too wide");
   a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
   a_event_follow: assert property (p_event_follow) else $error("no start event");
endmodule
bind freq_stage_status stage_status_monitor mon (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .START(START), .TRIP(TRIP),
   .BLOCKED(BLOCKED), .EVT_VALID(EVT_VALID), .EVT_CODE(EVT_CODE));

// File: block_matrix_model.sv
`timescale 1ns/100ps
module block_matrix_model (
   // clock
   input wire clk,
   // blocking request from the bench, one bit per stage
   input wire [7:0] want,
   // trip lines seen by the relays
   input wire [7:0] trip,
   // blocking lines and relay image
   output reg [7:0] blk,
   output reg [7:0] relay_q
);
   initial blk = 8'h00;
   initial relay_q = 8'h00;
   // lines move just after an edge, well ahead of any delay expiry
   always @(posedge clk)
   begin
      blk <= want;
      relay_q <= trip;
   end
endmodule

// File: freq_stage_status_tb.sv
`timescale 1ns/100ps
`include "fsl_map.vh"
module freq_stage_status_tb;
   localparam CC = 20;
   reg CLOCK = 1'b0;
   reg RST = 1'b1;
   reg [7:0] ADDR = 8'h00;
   reg [31:0] WDATA = 32'h0;
   reg WR = 1'b0;
   reg RD = 1'b0;
   reg [16:0] FREQ = 17'h0C350;
   reg [2:0] SET_GROUP = 3'h5;
   reg [31:0] TIME_STAMP = 32'h0;
   reg [7:0] want = 8'h00;
   wire [7:0] BLOCK, START, TRIP, BLOCKED, relay;
   wire [31:0] RDATA, EVT_TIME;
   wire EVT_VALID;
   wire [5:0] EVT_CODE;
   integer num_errors = 0;
   integer n_tests = 0;
   reg [5:0] evq[$];
   reg [31:0] tq[$];
   // 250 MHz clock
   initial forever #2 CLOCK = ~CLOCK;
   freq_stage_status #(.CYCLE_CLKS(CC)) dut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .FREQ(FREQ), .SET_GROUP(SET_GROUP),
      .TIME_STAMP(TIME_STAMP), .BLOCK(BLOCK), .START(START), .TRIP(TRIP), .BLOCKED(BLOCKED),
      .EVT_VALID(EVT_VALID), .EVT_CODE(EVT_CODE), .EVT_TIME(EVT_TIME));
   block_matrix_model far (.clk(CLOCK), .want(want), .trip(TRIP), .blk(BLOCK), .relay_q(relay));
   // main buffer image
   always @(posedge CLOCK)
      if (EVT_VALID)
      begin
         evq.push_back(EVT_CODE);
         tq.push_back(EVT_TIME);
      end
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         num_errors = num_errors + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
   begin
      @(posedge CLOCK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLOCK);
      WR <= 1'b0;
   end
   endtask
   task rd(input [7:0] a, input [31:0] exp);
   begin
      @(posedge CLOCK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1;
      chk(RDATA, exp);
   end
   endtask
   // wait for stage s output k (0 start, 1 trip, 2 blocked), bounded
   task wait_on(input integer s, input integer k);
      integer n;
   begin
      n = 0;
      do
      begin
         @(posedge CLOCK);
         #1;
         n = n + 1;
      end
      while (n < 60 && (k == 0 ? START[s] : k == 1 ? TRIP[s] : BLOCKED[s]) !== 1'b1);
      chk(n < 60, 1);
   end
   endtask
   task ticks(input integer n);
   begin
      repeat (n * CC) @(posedge CLOCK);
      #1;
   end
   endtask
   task tally_and_finish;
   begin
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask
   // watchdog
   initial
   begin
      #(4 * 20000);
      num_errors = num_errors + 1;
      tally_and_finish;
   end
   initial
   begin
      repeat (10) @(posedge CLOCK);
      RST <= 1'b0;
      rd(`A_MASK, 32'h3F);
      rd(`A_ENABLE, 32'h0);
      rd(`A_PICKUP, 32'h0C738);
      rd(`A_DELAY, 32'h14);
      rd(8'h20, 32'h0);
      wr(`A_SEL, 32'h4);
      rd(`A_PICKUP, 32'h0BF68);
      wr(`A_ENABLE, 32'h11);
      wr(`A_SEL, 32'h0);
      wr(`A_DELAY, 32'h3);
      rd(`A_EXPECT, 32'h3);
      ticks(5);
      // over stage 0: start, then trip exactly two cycles later
      @(posedge CLOCK) TIME_STAMP <= 32'h1111;
      FREQ <= 17'h0CB20;
      wait_on(0, 0);
      rd(`A_REMAIN, 32'h2);
      repeat (8) @(posedge CLOCK) TIME_STAMP <= 32'h2222;
      repeat (29) @(posedge CLOCK);
      #1 chk(TRIP, 8'h00);
      @(posedge CLOCK);
      #1 chk(TRIP, 8'h01);
      chk(START, 8'h01);
      rd(`A_STATUS, 32'h2);
      rd(`A_RATIO, 52000 * 1000 / 51000);
      rd(`A_CNT_START, 32'h1);
      rd(`A_CNT_TRIP, 32'h1);
      chk(relay, 8'h01);
      chk(evq.pop_front(), 6'h00);
      chk(tq.pop_front(), 32'h1111);
      chk(evq.pop_front(), 6'h02);
      chk(tq.pop_front(), 32'h2222);
      rd(`A_REC_COUNT, 32'h2);
      rd(`A_REC_EVENT, 32'h02);
      rd(`A_REC_TIME, 32'h2222);
      rd(`A_REC_FAULT, 32'h0CB20);
      rd(`A_REC_PRE, 32'h0C350);
      rd(`A_REC_GROUP, 32'h5);
      wr(`A_REC_SEL, 32'h1);
      rd(`A_REC_EVENT, 32'h00);
      rd(`A_REC_TIME, 32'h1111);
      wr(`A_CNT_START, 32'h0);
      rd(`A_CNT_START, 32'h0);
      // hysteresis band holds, below it the stage releases
      @(posedge CLOCK) FREQ <= 17'h0C72E;
      ticks(2);
      chk(TRIP, 8'h01);
      @(posedge CLOCK) FREQ <= 17'h0C71A;
      ticks(2);
      chk(START | TRIP, 8'h00);
      chk(evq.pop_front(), 6'h01);
      chk(evq.pop_front(), 6'h03);
      // pick-up while blocked
      @(posedge CLOCK) want <= 8'h01;
      ticks(1);
      @(posedge CLOCK) FREQ <= 17'h0CB20;
      wait_on(0, 2);
      chk(START, 8'h00);
      rd(`A_STATUS, 32'h3);
      rd(`A_CNT_BLK, 32'h1);
      chk(evq.pop_front(), 6'h04);
      wr(`A_MASK, 32'h1F);
      rd(`A_MASK, 32'h1F);
      @(posedge CLOCK) want <= 8'h00;
      FREQ <= 17'h0C350;
      ticks(2);
      chk(BLOCKED, 8'h00);
      chk(evq.size(), 0);
      wr(`A_MASK, 32'h3F);
      // under stage 4 blocked after start
      @(posedge CLOCK) FREQ <= 17'h0BB80;
      wait_on(4, 0);
      @(posedge CLOCK) want <= 8'h10;
      ticks(2);
      chk(START | TRIP, 8'h00);
      chk(evq.pop_front(), 6'h20);
      chk(evq.pop_front(), 6'h21);
      // forced trip on stage 0
      @(posedge CLOCK) want <= 8'h00;
      FREQ <= 17'h0C350;
      wr(`A_FORCE, 32'h2);
      wr(`A_CTRL, 32'h1);
      repeat (8) @(posedge CLOCK);
      #1 chk(TRIP[0], 1'b1);
      rd(`A_STATUS, 32'h2);
      wr(`A_CTRL, 32'h0);
      ticks(2);
      tally_and_finish;
   end
endmodule
